// *** scrs_regs.sv ***
`include "scrs_cfg.svh"

//Contract
// - buffered registers reach active copy on commit
// - decode configuration, index/transfer, program groups
// - every reset loads documented defaults, bit7 MSB
// - bit order select mirrored at bits 6,1
// - soft reset at bits 5,2; 0x18 reset
// - fixed part identifier at 0x01, read-only
// - speed grade code in bits 6:4 at 0x02
module scrs_regs
  import scrs_pkg::*;
#(
  parameter logic [7:0] PART_ID    = 8'hA5,  // arbitrary neutral value
  parameter logic [2:0] SPEED_CODE = 3'h0,
  parameter int         PROG_REGS  = 38
) (
  input  wire logic                   core_clk,
  input  wire logic                   rstn,
  input  wire logic                   sclk,
  input  wire logic                   csb_n,
  input  wire logic                   sdio_in,
  output logic                        sdio_out,
  output logic                        sdio_oe,
  output logic                        lsb_first,
  output logic [7:0]                  dev_index_hi,
  output logic [7:0]                  dev_index_lo,
  output logic [PROG_REGS*8-1:0]      prog_active
);
  localparam int AW = `SCRS_ADDR_W;
  localparam logic [7:0] PORT_RST = `SCRS_PORT_RST;
  localparam logic [AW-1:0] FIRST = `SCRS_ADDR_FIRST;

  if (PROG_REGS < 1 || PROG_REGS > int'(`SCRS_ADDR_LAST - `SCRS_ADDR_FIRST) + 1) begin : g_chk
    $error("PROG_REGS exceeds program register range");
  end

  logic [2:0] s_lvl, s_rise, s_fall;
  logic       sclk_rise, sclk_fall, csb_s, din_s;

  // pins cross into core_clk before anything reads them
  scrs_sync #(.W(3), .RST_VAL(16'h0002)) u_sync (
    .core_clk (core_clk),
    .rstn     (rstn),
    .pin_in   ({sdio_in, csb_n, sclk}),
    .pin_sync (s_lvl),
    .pin_rise (s_rise),
    .pin_fall (s_fall)
  );
  assign sclk_rise = s_rise[0];
  assign sclk_fall = s_fall[0];
  assign csb_s     = s_lvl[1];
  assign din_s     = s_lvl[2];

  // register state
  logic                   lsb_ff, srst_ff, commit_ff;
  logic [7:0]             idx2_ff, idx1_ff;
  logic [PROG_REGS*8-1:0] master_ff, active_ff;
  logic                   nxt_lsb, nxt_srst, nxt_commit;
  logic [7:0]             nxt_idx2, nxt_idx1;
  logic [PROG_REGS*8-1:0] nxt_master, nxt_active;

  // serial frame state
  scrs_state_t st_ff, nxt_st;
  logic [3:0]    cnt_ff, nxt_cnt;
  logic [15:0]   sh_ff, nxt_sh;
  logic [AW-1:0] addr_ff, nxt_addr;
  logic          rd_ff, nxt_rd, load_ff, nxt_load, oe_ff, nxt_oe, out_ff, nxt_out;
  logic [1:0]    wlen_ff, nxt_wlen, nbyte_ff, nxt_nbyte;
  logic [7:0]    tx_ff, nxt_tx;
  logic          wr_go;
  logic [7:0]    wr_byte;

  // power-up image of the program registers, bit 7 is MSB
  function automatic logic [PROG_REGS*8-1:0] prog_defaults();
    logic [PROG_REGS*8-1:0] v;
    v = '0;
    for (int i = 0; i < PROG_REGS; i++) begin
      if (FIRST + AW'(i) == `SCRS_ADDR_CLOCK) v[i*8 +: 8] = `SCRS_CLOCK_RST;
      else v[i*8 +: 8] = `SCRS_PROG_RST;
    end
    return v;
  endfunction
  // reset image held as a constant so the async reset branch loads constants only
  localparam logic [PROG_REGS*8-1:0] PROG_DFLT = prog_defaults();

  function automatic logic in_prog(input logic [AW-1:0] a);
    return (a >= FIRST) && (a < FIRST + AW'(PROG_REGS));
  endfunction

  // readback; undefined addresses answer zero
  function automatic logic [7:0] rd_byte(input logic [AW-1:0] a);
    logic [7:0] r;
    r = 8'h00;
    case (a)
      `SCRS_ADDR_PORT:   r = {1'b0, lsb_ff, srst_ff, 2'b11, srst_ff, lsb_ff, 1'b0};
      `SCRS_ADDR_ID:     r = PART_ID;
      `SCRS_ADDR_GRADE:  r = {1'b0, SPEED_CODE, 4'h0};
      `SCRS_ADDR_IDX2:   r = idx2_ff;
      `SCRS_ADDR_IDX1:   r = idx1_ff;
      `SCRS_ADDR_UPDATE: r = {7'h00, commit_ff};
      default: begin
        if (in_prog(a)) r = master_ff[int'(a - FIRST)*8 +: 8];
      end
    endcase
    return r;
  endfunction

  // frame decode: 16-bit instruction, then bytes, data out on falling edges
  always_comb begin
    nxt_st    = st_ff;
    nxt_cnt   = cnt_ff;
    nxt_sh    = sh_ff;
    nxt_addr  = addr_ff;
    nxt_rd    = rd_ff;
    nxt_wlen  = wlen_ff;
    nxt_nbyte = nbyte_ff;
    nxt_load  = load_ff;
    nxt_oe    = oe_ff;
    nxt_tx    = tx_ff;
    wr_go     = 1'b0;
    wr_byte   = 8'h00;
    if (csb_s) begin
      // deselect mid-byte simply restarts the frame
      nxt_st   = ST_INSTR;
      nxt_cnt  = 4'h0;
      nxt_load = 1'b0;
      nxt_oe   = 1'b0;
    end else begin
      if (sclk_rise && st_ff != ST_DONE) begin
        if (!lsb_ff) nxt_sh = {sh_ff[14:0], din_s};
        else if (st_ff == ST_INSTR) nxt_sh = {din_s, sh_ff[15:1]};
        else nxt_sh = {sh_ff[15:8], din_s, sh_ff[7:1]};
        nxt_cnt = cnt_ff + 4'h1;
        if (st_ff == ST_INSTR && cnt_ff == 4'(`SCRS_INSTR_BITS - 1)) begin
          nxt_st    = ST_DATA;
          nxt_cnt   = 4'h0;
          nxt_rd    = nxt_sh[15];
          nxt_wlen  = nxt_sh[14:13];
          nxt_addr  = nxt_sh[AW-1:0];
          nxt_nbyte = 2'h0;
          nxt_load  = nxt_sh[15];
        end else if (st_ff == ST_DATA && cnt_ff == 4'(`SCRS_BYTE_BITS - 1)) begin
          nxt_cnt   = 4'h0;
          wr_go     = !rd_ff;
          wr_byte   = nxt_sh[7:0];
          nxt_addr  = lsb_ff ? addr_ff + AW'(1) : addr_ff - AW'(1);
          nxt_nbyte = nbyte_ff + 2'h1;
          nxt_load  = rd_ff;
          if (wlen_ff != `SCRS_STREAM && nbyte_ff == wlen_ff) nxt_st = ST_DONE;
        end
      end
      if (sclk_fall && load_ff) begin
        nxt_tx   = rd_byte(addr_ff);
        nxt_load = 1'b0;
        nxt_oe   = 1'b1;
      end else if (sclk_fall && oe_ff) begin
        nxt_tx = lsb_ff ? {1'b0, tx_ff[7:1]} : {tx_ff[6:0], 1'b0};
      end
    end
    nxt_out = lsb_ff ? nxt_tx[0] : nxt_tx[7];
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st_ff    <= ST_INSTR;
      cnt_ff   <= 4'h0;
      sh_ff    <= 16'h0000;
      addr_ff  <= '0;
      rd_ff    <= 1'b0;
      wlen_ff  <= 2'h0;
      nbyte_ff <= 2'h0;
      load_ff  <= 1'b0;
      oe_ff    <= 1'b0;
      tx_ff    <= 8'h00;
      out_ff   <= 1'b0;
    end else begin
      st_ff    <= nxt_st;
      cnt_ff   <= nxt_cnt;
      sh_ff    <= nxt_sh;
      addr_ff  <= nxt_addr;
      rd_ff    <= nxt_rd;
      wlen_ff  <= nxt_wlen;
      nbyte_ff <= nxt_nbyte;
      load_ff  <= nxt_load;
      oe_ff    <= nxt_oe;
      tx_ff    <= nxt_tx;
      out_ff   <= nxt_out;
    end
  end

  // register writes; soft reset takes a whole cycle so nothing races it
  always_comb begin
    nxt_lsb    = lsb_ff;
    nxt_srst   = 1'b0;
    nxt_commit = 1'b0;
    nxt_idx2   = idx2_ff;
    nxt_idx1   = idx1_ff;
    nxt_master = master_ff;
    nxt_active = active_ff;
    if (srst_ff) begin
      nxt_lsb    = PORT_RST[`SCRS_LSB_HI];
      nxt_idx2   = `SCRS_IDX_RST;
      nxt_idx1   = `SCRS_IDX_RST;
      nxt_master = prog_defaults();
      nxt_active = prog_defaults();
    end else begin
      if (commit_ff) nxt_active = master_ff;
      if (wr_go) begin
        case (addr_ff)
          `SCRS_ADDR_PORT: begin
            // either mirror position works whatever the shift order
            nxt_lsb  = wr_byte[`SCRS_LSB_HI] | wr_byte[`SCRS_LSB_LO];
            nxt_srst = wr_byte[`SCRS_SRST_HI] | wr_byte[`SCRS_SRST_LO];
          end
          `SCRS_ADDR_IDX2:   nxt_idx2 = wr_byte;
          `SCRS_ADDR_IDX1:   nxt_idx1 = wr_byte;
          `SCRS_ADDR_UPDATE: nxt_commit = wr_byte[`SCRS_COMMIT_POS];
          default: begin
            // id and grade fall here and are ignored
            if (in_prog(addr_ff)) nxt_master[int'(addr_ff - FIRST)*8 +: 8] = wr_byte;
          end
        endcase
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      lsb_ff    <= PORT_RST[`SCRS_LSB_HI];
      srst_ff   <= PORT_RST[`SCRS_SRST_HI];
      commit_ff <= 1'b0;
      idx2_ff   <= `SCRS_IDX_RST;
      idx1_ff   <= `SCRS_IDX_RST;
      master_ff <= PROG_DFLT;
      active_ff <= PROG_DFLT;
    end else begin
      lsb_ff    <= nxt_lsb;
      srst_ff   <= nxt_srst;
      commit_ff <= nxt_commit;
      idx2_ff   <= nxt_idx2;
      idx1_ff   <= nxt_idx1;
      master_ff <= nxt_master;
      active_ff <= nxt_active;
    end
  end

  assign sdio_out     = out_ff;
  assign sdio_oe      = oe_ff;
  assign lsb_first    = lsb_ff;
  assign dev_index_hi = idx2_ff;
  assign dev_index_lo = idx1_ff;
  assign prog_active  = active_ff;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  a_commit_copy: assert property (commit_ff && !srst_ff |=> active_ff == $past(master_ff))
    else $error("commit did not copy pending values");
  a_active_hold: assert property (!commit_ff && !srst_ff |=> active_ff == $past(active_ff))
    else $error("active copy changed without commit");
  a_commit_clear: assert property (commit_ff && !wr_go |=> !commit_ff)
    else $error("commit bit did not self-clear");
  a_srst_defaults: assert property (srst_ff |=> !srst_ff && !lsb_ff && idx1_ff == 8'h0F
    && master_ff == prog_defaults() && active_ff == prog_defaults())
    else $error("soft reset did not restore defaults");
  a_port_layout: assert property (rd_byte(`SCRS_ADDR_PORT) ==
    ({1'b0, lsb_ff, srst_ff, 2'b00, srst_ff, lsb_ff, 1'b0} | 8'h18))
    else $error("port setup readback layout wrong");
  a_mirror_write: assert property (wr_go && addr_ff == `SCRS_ADDR_PORT && !srst_ff
    |=> lsb_ff == ($past(wr_byte[6]) | $past(wr_byte[1])))
    else $error("mirrored bit order not decoded");
  a_id_fixed: assert property (sclk_fall && load_ff && !csb_s
    && addr_ff == `SCRS_ADDR_ID |=> tx_ff == PART_ID)
    else $error("part identifier not returned");
  a_grade_field: assert property (sclk_fall && load_ff && !csb_s
    && addr_ff == `SCRS_ADDR_GRADE |=> tx_ff[6:4] == SPEED_CODE)
    else $error("speed grade field not returned");
  a_gap_decode: assert property (rd_byte(13'h003) == 8'h00 && rd_byte(13'h006) == 8'h00
    && rd_byte(13'h100) == 8'h00)
    else $error("undefined address decoded");
  a_reset_image: assert property ($rose(srst_ff) |-> ##1 idx2_ff == 8'h0F ##1 !srst_ff)
    else $error("reset image not loaded");
endmodule // scrs_regs

// *** scrs_cfg.svh ***
`ifndef SCRS_CFG_SVH
`define SCRS_CFG_SVH

// register addresses, 13-bit instruction address field
`define SCRS_ADDR_W        13
`define SCRS_ADDR_PORT     13'h000
`define SCRS_ADDR_ID       13'h001
`define SCRS_ADDR_GRADE    13'h002
`define SCRS_ADDR_IDX2     13'h004
`define SCRS_ADDR_IDX1     13'h005
`define SCRS_ADDR_UPDATE   13'h0FF
`define SCRS_ADDR_FIRST    13'h008
`define SCRS_ADDR_LAST     13'h02D
`define SCRS_ADDR_CLOCK    13'h009

// reset values
`define SCRS_PORT_RST      8'h18
`define SCRS_IDX_RST       8'h0F
`define SCRS_CLOCK_RST     8'h01
`define SCRS_PROG_RST      8'h00
`define SCRS_UPDATE_RST    8'h00

// field positions
`define SCRS_LSB_HI        6
`define SCRS_LSB_LO        1
`define SCRS_SRST_HI       5
`define SCRS_SRST_LO       2
`define SCRS_COMMIT_POS    0
`define SCRS_GRADE_POS     4

// frame counts
`define SCRS_INSTR_BITS    16
`define SCRS_BYTE_BITS     8
`define SCRS_STREAM        2'h3

`endif

// *** scrs_pkg.sv ***
package scrs_pkg;
  // serial frame phase
  typedef enum logic [1:0] {
    ST_INSTR = 2'b00,
    ST_DATA  = 2'b01,
    ST_DONE  = 2'b10
  } scrs_state_t;
endpackage

// *** scrs_sync.sv ***
module scrs_sync #(
  parameter int          W       = 1,
  parameter logic [15:0] RST_VAL = 16'h0000
) (
  input  wire logic         core_clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] pin_sync,
  output logic      [W-1:0] pin_rise,
  output logic      [W-1:0] pin_fall
);
  logic [W-1:0] s1_ff, s2_ff, s3_ff;
  logic [W-1:0] nxt_s1, nxt_s2, nxt_s3;

  if (W < 1 || W > 16) begin : g_chk
    $error("scrs_sync width must be 1 to 16");
  end

  // stage one feeds stage two only; edges come from two and three
  always_comb begin
    nxt_s1 = pin_in;
    nxt_s2 = s1_ff;
    nxt_s3 = s2_ff;
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s1_ff <= RST_VAL[W-1:0];
      s2_ff <= RST_VAL[W-1:0];
      s3_ff <= RST_VAL[W-1:0];
    end else begin
      s1_ff <= nxt_s1;
      s2_ff <= nxt_s2;
      s3_ff <= nxt_s3;
    end
  end

  // edge pulses, one core cycle each
  assign pin_sync = s2_ff;
  assign pin_rise = s2_ff & ~s3_ff;
  assign pin_fall = ~s2_ff & s3_ff;
endmodule // scrs_sync

// *** scrs_host.sv ***
module scrs_host (
  input  wire logic core_clk,
  input  wire logic sdio_out,
  input  wire logic sdio_oe,
  output logic      sclk,
  output logic      csb_n,
  output logic      sdio_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       drv;
  logic       bit_d;
  logic       pat;
  logic       oe_ok;
  logic [7:0] buf_q [4];

  initial begin
    sclk = 1'b0;
    csb_n = 1'b1;
    drv = 1'b0;
    bit_d = 1'b0;
    pat = 1'b0;
    oe_ok = 1'b1;
  end
  // released line toggles so a stale bit never passes for read data
  always @(posedge core_clk) pat <= ~pat;
  assign sdio_in = drv ? bit_d : (sdio_oe ? sdio_out : pat);

  // one link period of 8 core cycles; sample just before the fall
  task automatic tick(output logic smp);
    repeat (4) @(posedge core_clk);
    sclk <= 1'b1;
    repeat (4) @(posedge core_clk);
    smp = sdio_out;
    sclk <= 1'b0;
  endtask

  // whole frame of n bytes; sclk rests low outside it
  task automatic frame(input logic rd, input logic [12:0] addr, input int n, input logic lsb);
    logic [15:0] ins;
    logic        s;
    int          k;
    ins = {rd, 2'(n - 1), addr};
    oe_ok = 1'b1;
    csb_n <= 1'b0;
    drv <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      bit_d <= ins[lsb ? i : 15 - i];
      tick(s);
      oe_ok = oe_ok & !sdio_oe;
    end
    for (int b = 0; b < 8 * n; b++) begin
      k = lsb ? b % 8 : 7 - b % 8;
      drv <= ~rd;
      bit_d <= buf_q[b / 8][k];
      tick(s);
      if (rd) buf_q[b / 8][k] = s;
      // device must drive only in read data phases
      oe_ok = oe_ok & (sdio_oe == rd);
    end
    repeat (4) @(posedge core_clk);
    csb_n <= 1'b1;
    drv <= 1'b0;
    repeat (12) @(posedge core_clk);
  endtask

  // mirrors written alike, fixed bits as they read back
  function automatic logic [7:0] port_byte(input logic l, input logic s);
    return {1'b0, l, s, 2'b11, s, l, 1'b0};
  endfunction
endmodule // scrs_host

// *** spi_config_register_space_tb.sv ***
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin error_cnt++; \
  $display("[FAIL] %0t got %h exp %h", $time, got, exp); end end

module spi_config_register_space_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] PART_ID = 8'h3C;  // arbitrary value
  localparam logic [2:0] SPEED   = 3'h2;
  localparam int         NPROG   = 38;
  logic               core_clk;
  logic               rstn;
  logic               sclk;
  logic               csb_n;
  logic               sdio_in;
  logic               sdio_out;
  logic               sdio_oe;
  logic               lsb_first;
  logic [7:0]         idx_hi;
  logic [7:0]         idx_lo;
  logic [NPROG*8-1:0] prog;
  int                 error_cnt;
  int                 samples_checked;
  integer             seed;
  int                 a;
  logic [7:0]         v;
  logic [7:0]         w;
  logic [7:0]         exp_m [NPROG];

  scrs_regs #(.PART_ID(PART_ID), .SPEED_CODE(SPEED), .PROG_REGS(NPROG)) dut_u (
    .core_clk(core_clk), .rstn(rstn), .sclk(sclk), .csb_n(csb_n), .sdio_in(sdio_in),
    .sdio_out(sdio_out), .sdio_oe(sdio_oe), .lsb_first(lsb_first),
    .dev_index_hi(idx_hi), .dev_index_lo(idx_lo), .prog_active(prog));
  scrs_host host_u (.core_clk(core_clk), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
    .sclk(sclk), .csb_n(csb_n), .sdio_in(sdio_in));

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // only the clock register leaves reset non-zero
  function automatic logic [7:0] dflt(input int i);
    return (i == 1) ? 8'h01 : 8'h00;
  endfunction

  // every frame also checks the direction of the data pin
  task automatic xfer(input logic r, input logic [12:0] ad, input int n, input logic l);
    host_u.frame(r, ad, n, l);
    `CHK(host_u.oe_ok, 1'b1)
    `CHK(sdio_oe, 1'b0)
  endtask

  task automatic wr(input logic [12:0] ad, input logic [7:0] d, input logic l);
    host_u.buf_q[0] = d;
    xfer(1'b0, ad, 1, l);
  endtask

  task automatic rd(input logic [12:0] ad, input logic l, output logic [7:0] d);
    xfer(1'b1, ad, 1, l);
    d = host_u.buf_q[0];
  endtask

  // active copies against the bench's own image of committed values
  task automatic check_active();
    for (int i = 0; i < NPROG; i++) `CHK(prog[i*8 +: 8], exp_m[i])
  endtask

  task automatic check_defaults();
    for (int i = 0; i < NPROG; i++) `CHK(prog[i*8 +: 8], dflt(i))
    `CHK(idx_hi, 8'h0F)
    `CHK(idx_lo, 8'h0F)
    `CHK(lsb_first, 1'b0)
  endtask

  task automatic print_verdict();
    $display("errors %0d checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // a hung frame would otherwise run forever
  initial begin
    repeat (40000) @(posedge core_clk);
    error_cnt++;
    print_verdict();
  end

  initial begin
    seed = 32'h11ec3adb;
    error_cnt = 0;
    samples_checked = 0;
    for (int i = 0; i < NPROG; i++) exp_m[i] = dflt(i);
    rstn = 1'b0;
    repeat (16) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (4) @(posedge core_clk);
    check_defaults();
    rd(13'h000, 1'b0, v);
    `CHK(v, 8'h18)
    rd(13'h001, 1'b0, v);
    `CHK(v, PART_ID)
    wr(13'h001, ~PART_ID, 1'b0);
    rd(13'h001, 1'b0, v);
    `CHK(v, PART_ID)
    wr(13'h002, 8'hFF, 1'b0);
    rd(13'h002, 1'b0, v);
    `CHK(v[6:4], SPEED)
    rd(13'h003, 1'b0, v);
    `CHK(v, 8'h00)
    rd(13'h008 + 13'(NPROG), 1'b0, v);
    `CHK(v, 8'h00)
    // random program writes wait in the master copy, last address first
    for (int i = 0; i < 6; i++) begin
      a = (i == 0) ? NPROG - 1 : ($random(seed) & 32'h7FFFFFFF) % NPROG;
      w = 8'($random(seed));
      wr(13'h008 + 13'(a), w, 1'b0);
      exp_m[a] = w;
      `CHK(prog[a*8 +: 8], dflt(a))
      rd(13'h008 + 13'(a), 1'b0, v);
      `CHK(v, w)
    end
    wr(13'h0FF, 8'h01, 1'b0);
    check_active();
    rd(13'h0FF, 1'b0, v);
    `CHK(v[0], 1'b0)
    rd(13'h008 + 13'(NPROG - 1), 1'b0, v);
    `CHK(v, exp_m[NPROG-1])
    // two-byte index write, address falls from 0x05 to 0x04
    host_u.buf_q[0] = 8'($random(seed));
    host_u.buf_q[1] = 8'($random(seed));
    v = host_u.buf_q[0];
    w = host_u.buf_q[1];
    xfer(1'b0, 13'h005, 2, 1'b0);
    `CHK(idx_lo, v)
    `CHK(idx_hi, w)
    // bit order flip
    wr(13'h000, host_u.port_byte(1'b1, 1'b0), 1'b0);
    `CHK(lsb_first, 1'b1)
    rd(13'h000, 1'b1, v);
    `CHK(v, 8'h5A)
    rd(13'h001, 1'b1, v);
    `CHK(v, PART_ID)
    // lsb first stream write climbs from 0x08; active copies must not move yet
    for (int i = 0; i < 4; i++) host_u.buf_q[i] = 8'($random(seed));
    xfer(1'b0, 13'h008, 4, 1'b1);
    check_active();
    for (int i = 0; i < 4; i++) exp_m[i] = host_u.buf_q[i];
    // three-byte read from 0x09 upward returns the pending values
    xfer(1'b1, 13'h009, 3, 1'b1);
    for (int i = 0; i < 3; i++) `CHK(host_u.buf_q[i], exp_m[i + 1])
    wr(13'h0FF, 8'h01, 1'b1);
    check_active();
    // soft reset sent lsb first
    wr(13'h000, host_u.port_byte(1'b1, 1'b1), 1'b1);
    check_defaults();
    rd(13'h000, 1'b0, v);
    `CHK(v, 8'h18)
    rd(13'h008 + 13'(NPROG - 1), 1'b0, v);
    `CHK(v, dflt(NPROG - 1))
    print_verdict();
  end
endmodule // spi_config_register_space_tb
